// File: bench/e3dm_upstream_model.sv
// e3dm_upstream_model: upstream path end that feeds gapped, class-tagged bits
// assumes the bench calls its tasks just after a rising edge of clk_i
`timescale 1ns/1ps
module e3dm_upstream_model (
  // system clock
  input wire logic clk_i,
  // link pins toward the sink
  output logic link_clk_o,
  output logic link_data_o,
  output logic [2:0] link_cls_o
);
  // ==========================================================
  // link bit level
  // link clock parks low between bursts, never free running
  initial begin
    link_clk_o = 1'b0;
    link_data_o = 1'b0;
    link_cls_o = 3'h7;
  end
  // 800 ns per bit: data set, 4 cycles low, rise, 4 cycles hold
  task automatic send_bit(input logic d, input e3dm_pkg::e3dm_cls_t c);
    link_data_o <= d;
    link_cls_o <= c;
    repeat (4) @(posedge clk_i);
    link_clk_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    link_clk_o <= 1'b0;
  endtask : send_bit
  // hold time over: the line stops showing the last bit
  task automatic park();
    @(posedge clk_i);
    link_data_o <= ~link_data_o;
    link_cls_o <= e3dm_pkg::CLS_OTHER;
  endtask : park
  task automatic send_ctl(input logic [4:0] v, input e3dm_pkg::e3dm_cls_t c);
    for (int k = 4; k >= 0; k--) send_bit(v[k], c);
  endtask : send_ctl
  // label byte goes msb first
  task automatic send_byte(input logic [7:0] v);
    for (int k = 7; k >= 0; k--) send_bit(v[k], e3dm_pkg::CLS_LABEL);
  endtask : send_byte
  // ==========================================================
  // one 1536-bit tributary frame with overhead mixed in
  // a wrongly kept or dropped bit shifts the frame and breaks alignment
  task automatic send_frame();
    logic [9:0] fas;
    logic d;
    fas = e3dm_pkg::FAS_WORD;
    for (int i = 0; i < 1536; i++) begin
      d = (i < 10) ? fas[9 - i] : (i % 3 == 0);
      if (i == 500) begin
        send_bit(1'b0, e3dm_pkg::CLS_FIXED);
        send_ctl(5'h1f, e3dm_pkg::CLS_OTHER);
        send_ctl(5'h1a, e3dm_pkg::CLS_C1);
        send_bit(1'b0, e3dm_pkg::CLS_S1);
        send_ctl(5'h09, e3dm_pkg::CLS_C2);
        send_bit(d, e3dm_pkg::CLS_S2);
      end else if (i == 900) begin
        send_ctl(5'h05, e3dm_pkg::CLS_C1);
        send_bit(d, e3dm_pkg::CLS_S1);
        send_ctl(5'h1c, e3dm_pkg::CLS_C2);
        send_bit(1'b0, e3dm_pkg::CLS_S2);
      end else begin
        send_bit(d, e3dm_pkg::CLS_DATA);
      end
    end
  endtask : send_frame
endmodule : e3dm_upstream_model

// File: bench/testbench.sv
// testbench: register, label, alignment and insertion tests of e3dm_sink
// assumes e3dm_pkg and the upstream model are compiled first
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // signals
  logic clk_i, rst_n_i, tsf, lclk, ldata;
  logic [2:0] lcls;
  logic trib_data, trib_clk, marker, ssf, f_plm, f_lof, f_ais, tclk_q;
  logic [7:0] label_o, awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int failures = 0, n_checks = 0, n_mark = 0, last_gap = 0, bitcnt = 0, zeros = 0, tbits = 0;
  e3dm_upstream_model up (.clk_i(clk_i), .link_clk_o(lclk), .link_data_o(ldata), .link_cls_o(lcls));
  e3dm_sink uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(lclk), .link_data_i(ldata),
    .link_cls_i(lcls), .upstream_trail_fail_i(tsf), .trib_data_o(trib_data), .trib_clk_o(trib_clk),
    .frame_start_marker_o(marker), .server_fail_out_o(ssf), .accepted_label_status_o(label_o),
    .label_mismatch_fault_o(f_plm), .frame_loss_fault_o(f_lof), .all_ones_fault_o(f_ais),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_araddr_i(araddr),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp));
  // ==========================================================
  // clock and monitor of the smoothed output
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // counts smoothed bits between frame markers and zeros seen
  always @(posedge clk_i) begin
    tclk_q <= trib_clk;
    if (trib_clk && !tclk_q) begin
      tbits <= tbits + 1;
      if (!trib_data) zeros <= zeros + 1;
    end
    if (marker) begin
      n_mark <= n_mark + 1;
      last_gap <= bitcnt + 32'(trib_clk && !tclk_q);
      bitcnt <= 0;
    end else begin
      bitcnt <= bitcnt + 32'(trib_clk && !tclk_q);
    end
  end
  // ==========================================================
  // tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  // address and data offered together, each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    rs = 2'h3;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        bready <= 1'b0;
        return;
      end
    end
    failures++;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rs = 2'h3;
    d = '0;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rs = rresp;
        d = rdata;
        rready <= 1'b0;
        return;
      end
    end
    failures++;
  endtask : axi_rd
  // ==========================================================
  // watchdog: tests need about 70000 cycles
  initial begin
    repeat (90000) @(posedge clk_i);
    failures++;
    end_sim();
  end
  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] rd;
    logic [1:0] rs;
    int t0;
    int z0;
    int m0;
    rst_n_i = 1'b0;
    tsf = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hf};
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk("trib_data_idle", 1, 32'(trib_data));
    chk("label_idle", 0, 32'(label_o));
    axi_rd(e3dm_pkg::ADDR_CTRL, rd, rs);
    chk("ctrl_reset", 32'(e3dm_pkg::CTRL_RESET), rd);
    axi_rd(8'h0c, rd, rs);
    chk("unmapped_resp", 32'(e3dm_pkg::RESP_SLVERR), 32'(rs));
    chk("unmapped_data", 0, rd);
    axi_wr(e3dm_pkg::ADDR_CTRL, 32'h0000_0003, rs);
    chk("ctrl_bresp", 32'(e3dm_pkg::RESP_OKAY), 32'(rs));
    axi_rd(e3dm_pkg::ADDR_CTRL, rd, rs);
    chk("ctrl_readback", 32'h0000_0003, rd);
    repeat (8) @(posedge clk_i);
    chk("plm_fault_unaccepted", 1, 32'(f_plm));
    chk("lof_fault_under_plm", 0, 32'(f_lof));
    chk("server_fail_plm", 1, 32'(ssf));
    $display("test registers done");
    repeat (5) up.send_byte(e3dm_pkg::LABEL_EXPECTED);
    up.park();
    repeat (8) @(posedge clk_i);
    chk("label_out", 32'(e3dm_pkg::LABEL_EXPECTED), 32'(label_o));
    chk("plm_fault_match", 0, 32'(f_plm));
    chk("lof_fault_search", 1, 32'(f_lof));
    axi_rd(e3dm_pkg::ADDR_LABEL, rd, rs);
    chk("label_reg", 32'(e3dm_pkg::LABEL_EXPECTED), rd);
    $display("test label done");
    m0 = n_mark;
    z0 = zeros;
    repeat (5) up.send_frame();
    chk("markers_seen", 1, 32'(n_mark - m0 >= 2));
    chk("frame_gap", 1536, last_gap);
    chk("lof_fault_aligned", 0, 32'(f_lof));
    chk("server_fail_clear", 0, 32'(ssf));
    chk("data_flows", 1, 32'(zeros > z0));
    up.park();
    $display("test alignment done");
    tsf <= 1'b1;
    repeat (e3dm_pkg::AIS_CYC) @(posedge clk_i);
    chk("server_fail_tsf", 1, 32'(ssf));
    z0 = zeros;
    t0 = tbits;
    repeat (400) @(posedge clk_i);
    chk("all_ones_out", 0, zeros - z0);
    chk("clk_rate_ok", 1, 32'((tbits - t0) >= 48 && (tbits - t0) <= 52));
    repeat (5) up.send_byte(8'h12);
    up.park();
    repeat (8) @(posedge clk_i);
    chk("label_new", 32'h0000_0012, 32'(label_o));
    chk("plm_fault_tsf", 0, 32'(f_plm));
    tsf <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("plm_fault_wrong", 1, 32'(f_plm));
    chk("lof_fault_plm", 0, 32'(f_lof));
    chk("ais_fault_plm", 0, 32'(f_ais));
    chk("server_fail_wrong", 1, 32'(ssf));
    $display("test defects done");
    axi_wr(e3dm_pkg::ADDR_CTRL, 32'h0000_0000, rs);
    repeat (8) @(posedge clk_i);
    chk("trib_data_off", 1, 32'(trib_data));
    chk("plm_fault_off", 0, 32'(f_plm));
    chk("label_off", 0, 32'(label_o));
    axi_rd(e3dm_pkg::ADDR_STATUS, rd, rs);
    chk("status_off", 0, rd);
    $display("test deactivate done");
    end_sim();
  end
endmodule : testbench

// File: hdl/e3dm_sink.sv
// e3dm_sink: e3 tributary demapper sink with alignment, defects, axi4-lite regs
// assumes upstream tags every gapped payload bit with its class on the link clock
//
// Behaviour
// - accepted label compared to 0000_0100; mismatch raises label mismatch defect.
// - h4 overhead byte content is ignored.
// - fixed-stuff r bits are ignored.
// - c1 majority zero makes s1 data; majority one discards s1.
// - c2 majority zero makes s2 data; majority one discards s2.
// - bits written on gapped link clock, read by evenly spaced smoothed clock.
// - elastic store deep enough for plus or minus 20 ppm with jitter.
// - after frequency step, store recentres so errors stop quickly.
// - inactive drives all-ones and suppresses all management status.
// - search tributary for frame alignment word, mark frame start when aligned.
// - four consecutive missed alignment words declare loss of frame.
// - three consecutive correct alignment words regain alignment, clear loss of frame.
// - after one candidate, miss in either next two frames restarts search.
// - all-ones defect detected with x 4, y 1536, z 5.
// - server fail and all-ones insertion from mismatch, lof, ais or upstream fail.
// - all-ones within 250 us of insertion, normal data within 250 us after.
// - output clock keeps running while all-ones inserted, still trimmed by fill: nominal minus trim below half fill.
// - lof fault only with lof and no ais defect and no label mismatch.
// - ais fault only with ais, no mismatch, no upstream fail, reporting enabled.
// - label mismatch fault only with mismatch and no upstream fail.
`timescale 1ns/1ps
module e3dm_sink (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // upstream adaptation side (asynchronous pins)
  input wire logic link_clk_i,
  input wire logic link_data_i,
  input wire logic [2:0] link_cls_i,
  input wire logic upstream_trail_fail_i,
  // tributary side
  output logic trib_data_o,
  output logic trib_clk_o,
  output logic frame_start_marker_o,
  output logic server_fail_out_o,
  // management status
  output logic [7:0] accepted_label_status_o,
  output logic label_mismatch_fault_o,
  output logic frame_loss_fault_o,
  output logic all_ones_fault_o,
  // axi4-lite slave
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [7:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o
);
  // ==========================================================
  // state
  typedef struct packed {
    e3dm_pkg::e3dm_in_t s1, s2, s3;
    logic lclk;
    logic act_prev;
    logic [7:0] lbl_sh, lbl_cand, lbl_acc;
    logic [2:0] lbl_idx, lbl_cnt;
    logic [2:0] c1_ones, c2_ones;
    logic [e3dm_pkg::STORE_DEPTH-1:0] mem;
    logic [5:0] wp, rp;
    logic [15:0] nco;
    logic dout;
    e3dm_pkg::e3dm_fas_t fas;
    logic [9:0] fas_sh;
    logic [10:0] bit_cnt;
    logic [2:0] miss;
    logic lof, fsm_pulse;
    logic [2:0] zcnt, ais_run, clr_run;
    logic [10:0] per_cnt;
    logic ais, plm, ssf;
    logic f_plm, f_lof, f_ais;
    logic aw_v, w_v;
    e3dm_pkg::e3dm_word_t wr;
    logic wstrb0;
    logic bvalid, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [1:0] ctrl;
  } e3dm_state_t;
  e3dm_state_t st_r, st_nxt;

  // register address decode, used by both read and write paths
  function automatic logic e3dm_mapped(input logic [7:0] a);
    e3dm_mapped = (a == e3dm_pkg::ADDR_CTRL) || (a == e3dm_pkg::ADDR_STATUS) ||
      (a == e3dm_pkg::ADDR_LABEL);
  endfunction : e3dm_mapped

  logic act, edge_w, wr_bit, rd, hit, chk, rbit, insert;
  logic [5:0] fill;
  logic [15:0] inc;
  logic [16:0] sum;
  logic [9:0] fas_new;
  logic [10:0] bc_new;
  logic [7:0] byte_new;
  logic [2:0] zc_new;

  // ==========================================================
  // next-state logic
  always_comb begin
    st_nxt = st_r;
    act = st_r.ctrl[e3dm_pkg::CTRL_ACT_BIT];
    // three-stage sampling; a level counts once stages two and three agree
    st_nxt.s1 = '{lclk: link_clk_i, data: link_data_i, cls: e3dm_pkg::e3dm_cls_t'(link_cls_i),
      tsf: upstream_trail_fail_i};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2.lclk == st_r.s3.lclk) begin
      st_nxt.lclk = st_r.s3.lclk;
    end
    edge_w = (st_r.s2.lclk == st_r.s3.lclk) && st_r.s3.lclk && !st_r.lclk;
    fill = st_r.wp - st_r.rp;
    wr_bit = 1'b0;
    byte_new = {st_r.lbl_sh[6:0], st_r.s3.data};
    if (edge_w) begin
      unique case (st_r.s3.cls)
        e3dm_pkg::CLS_DATA: wr_bit = 1'b1;
        e3dm_pkg::CLS_C1: st_nxt.c1_ones = st_r.c1_ones + {2'h0, st_r.s3.data};
        e3dm_pkg::CLS_C2: st_nxt.c2_ones = st_r.c2_ones + {2'h0, st_r.s3.data};
        e3dm_pkg::CLS_S1: begin
          wr_bit = st_r.c1_ones < e3dm_pkg::CTRL_MAJORITY;
          st_nxt.c1_ones = '0;
        end
        e3dm_pkg::CLS_S2: begin
          wr_bit = st_r.c2_ones < e3dm_pkg::CTRL_MAJORITY;
          st_nxt.c2_ones = '0;
        end
        e3dm_pkg::CLS_LABEL: begin
          st_nxt.lbl_sh = byte_new;
          st_nxt.lbl_idx = st_r.lbl_idx + 3'h1;
          if (st_r.lbl_idx == e3dm_pkg::LABEL_LAST_IDX) begin
            // persistence filter before a new label is accepted
            if (byte_new == st_r.lbl_cand) begin
              if (st_r.lbl_cnt != e3dm_pkg::LABEL_ACCEPT_N) st_nxt.lbl_cnt = st_r.lbl_cnt + 3'h1;
              if (st_r.lbl_cnt + 3'h1 >= e3dm_pkg::LABEL_ACCEPT_N) st_nxt.lbl_acc = byte_new;
            end else begin
              st_nxt.lbl_cand = byte_new;
              st_nxt.lbl_cnt = 3'h1;
            end
          end
        end
        default: ; // r bits and h4/other overhead carry nothing we use
      endcase
    end
    if (wr_bit) begin // gapped write side of the elastic store
      st_nxt.mem[st_r.wp] = st_r.s3.data;
      st_nxt.wp = st_r.wp + 6'h1;
    end
    // smoothed read clock: nco trimmed gently toward half fill, so spacing stays even
    inc = e3dm_pkg::NCO_NOMINAL;
    if (fill > e3dm_pkg::STORE_HALF) inc = e3dm_pkg::NCO_NOMINAL + e3dm_pkg::NCO_TRIM;
    if (fill < e3dm_pkg::STORE_HALF) inc = e3dm_pkg::NCO_NOMINAL - e3dm_pkg::NCO_TRIM;
    sum = {1'b0, st_r.nco} + {1'b0, inc};
    st_nxt.nco = sum[15:0];
    rd = sum[16];
    rbit = st_r.mem[st_r.rp];
    if (rd) begin
      st_nxt.rp = st_r.rp + 6'h1;
    end
    // slip or activation recentres the store; 64 bits covers 20 ppm plus jitter
    st_nxt.act_prev = act;
    if ((rd && fill == 6'h0) || (wr_bit && fill == e3dm_pkg::STORE_FULL) || (act && !st_r.act_prev)) begin
      st_nxt.rp = st_nxt.wp - e3dm_pkg::STORE_HALF;
    end
    // frame alignment on recovered bits
    fas_new = {st_r.fas_sh[8:0], rbit};
    hit = fas_new == e3dm_pkg::FAS_WORD;
    bc_new = (st_r.bit_cnt == e3dm_pkg::FRAME_LAST) ? 11'h0 : st_r.bit_cnt + 11'h1;
    chk = bc_new == 11'h0;
    st_nxt.fsm_pulse = 1'b0;
    zc_new = st_r.zcnt;
    if (rd) begin
      st_nxt.fas_sh = fas_new;
      st_nxt.bit_cnt = bc_new;
      unique case (st_r.fas)
        e3dm_pkg::FAS_SRCH: if (hit) begin
          st_nxt.fas = e3dm_pkg::FAS_CHK1;
          st_nxt.bit_cnt = 11'h0;
        end
        e3dm_pkg::FAS_CHK1: if (chk) st_nxt.fas = hit ? e3dm_pkg::FAS_CHK2 : e3dm_pkg::FAS_SRCH;
        e3dm_pkg::FAS_CHK2: if (chk) begin
          st_nxt.fas = hit ? e3dm_pkg::FAS_SYNC : e3dm_pkg::FAS_SRCH;
          if (hit) begin
            st_nxt.lof = 1'b0;
            st_nxt.miss = 3'h0;
          end
        end
        e3dm_pkg::FAS_SYNC: if (chk) begin
          st_nxt.fsm_pulse = hit;
          st_nxt.miss = hit ? 3'h0 : st_r.miss + 3'h1;
          if (!hit && st_r.miss + 3'h1 == e3dm_pkg::LOF_MISSES) begin
            st_nxt.fas = e3dm_pkg::FAS_SRCH;
            st_nxt.lof = 1'b1;
          end
        end
      endcase
      // all-ones defect: zeros counted per y-bit period
      // the closing bit of a period counts too, so the verdict reads zc_new
      if (!rbit && st_r.zcnt != e3dm_pkg::AIS_X) zc_new = st_r.zcnt + 3'h1;
      st_nxt.zcnt = zc_new;
      st_nxt.per_cnt = st_r.per_cnt + 11'h1;
      if (st_r.per_cnt == e3dm_pkg::AIS_Y_LAST) begin
        st_nxt.per_cnt = 11'h0;
        st_nxt.zcnt = 3'h0;
        if (zc_new < e3dm_pkg::AIS_X) begin
          st_nxt.clr_run = 3'h0;
          if (st_r.ais_run != e3dm_pkg::AIS_Z) st_nxt.ais_run = st_r.ais_run + 3'h1;
          if (st_r.ais_run + 3'h1 >= e3dm_pkg::AIS_Z) st_nxt.ais = 1'b1;
        end else begin
          st_nxt.ais_run = 3'h0;
          if (st_r.clr_run != e3dm_pkg::AIS_Z) st_nxt.clr_run = st_r.clr_run + 3'h1;
          if (st_r.clr_run + 3'h1 >= e3dm_pkg::AIS_Z) st_nxt.ais = 1'b0;
        end
      end
    end
    // defects, consequent actions and correlations
    st_nxt.plm = st_r.lbl_acc != e3dm_pkg::LABEL_EXPECTED;
    st_nxt.ssf = st_r.plm | st_r.lof | st_r.ais | st_r.s3.tsf;
    insert = st_r.ssf | !act;
    // insertion takes effect on the next bit, far inside 250 us
    if (rd) st_nxt.dout = insert ? 1'b1 : rbit;
    st_nxt.f_lof = act & st_r.lof & !st_r.ais & !st_r.plm;
    st_nxt.f_ais = act & st_r.ais & !st_r.plm & !st_r.s3.tsf & st_r.ctrl[e3dm_pkg::CTRL_AISREP_BIT];
    st_nxt.f_plm = act & st_r.plm & !st_r.s3.tsf;
    // axi4-lite write: address and data taken in either order
    if (s_axi_awvalid_i && !st_r.aw_v) begin
      st_nxt.aw_v = 1'b1;
      st_nxt.wr.addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !st_r.w_v) begin
      st_nxt.w_v = 1'b1;
      st_nxt.wr.data = s_axi_wdata_i;
      st_nxt.wstrb0 = s_axi_wstrb_i[0]; // strobe kept with its data, never read live later
    end
    if (st_r.aw_v && st_r.w_v && !st_r.bvalid) begin
      st_nxt.aw_v = 1'b0;
      st_nxt.w_v = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = e3dm_mapped(st_r.wr.addr) ? e3dm_pkg::RESP_OKAY : e3dm_pkg::RESP_SLVERR;
      if (st_r.wr.addr == e3dm_pkg::ADDR_CTRL && st_r.wstrb0) st_nxt.ctrl = st_r.wr.data[1:0];
    end
    if (st_r.bvalid && s_axi_bready_i) st_nxt.bvalid = 1'b0;
    // axi4-lite read: one outstanding, unmapped reads zero with slverr
    if (s_axi_arvalid_i && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = e3dm_mapped(s_axi_araddr_i) ? e3dm_pkg::RESP_OKAY : e3dm_pkg::RESP_SLVERR;
      unique case (s_axi_araddr_i)
        e3dm_pkg::ADDR_CTRL: st_nxt.rdata = {30'h0, st_r.ctrl};
        e3dm_pkg::ADDR_STATUS: st_nxt.rdata = {18'h0, act ? fill : 6'h00, act & st_r.ssf, act & st_r.ais,
          act & st_r.lof, act & st_r.plm, 1'b0, st_r.f_ais, st_r.f_lof, st_r.f_plm};
        e3dm_pkg::ADDR_LABEL: st_nxt.rdata = {24'h0, act ? st_r.lbl_acc : 8'h00};
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (st_r.rvalid && s_axi_rready_i) st_nxt.rvalid = 1'b0;
  end

  // ==========================================================
  // state register; reset values are constants only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
      st_r.mem <= '1;
      st_r.rp <= 6'h0 - e3dm_pkg::STORE_HALF;
      st_r.dout <= 1'b1;
      st_r.lof <= 1'b1;
      st_r.plm <= 1'b1;
      st_r.ssf <= 1'b1;
      st_r.ctrl <= e3dm_pkg::CTRL_RESET;
      st_r.fas <= e3dm_pkg::FAS_SRCH;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign trib_data_o = st_r.dout;
  assign trib_clk_o = st_r.nco[15]; // rises mid-bit so the data are stable at the edge
  assign frame_start_marker_o = st_r.fsm_pulse;
  assign server_fail_out_o = st_r.ssf;
  assign accepted_label_status_o = st_r.ctrl[e3dm_pkg::CTRL_ACT_BIT] ? st_r.lbl_acc : 8'h00;
  assign label_mismatch_fault_o = st_r.f_plm;
  assign frame_loss_fault_o = st_r.f_lof;
  assign all_ones_fault_o = st_r.f_ais;
  assign s_axi_awready_o = !st_r.aw_v;
  assign s_axi_wready_o = !st_r.w_v;
  assign s_axi_bvalid_o = st_r.bvalid;
  assign s_axi_bresp_o = st_r.bresp;
  assign s_axi_arready_o = !st_r.rvalid;
  assign s_axi_rvalid_o = st_r.rvalid;
  assign s_axi_rdata_o = st_r.rdata;
  assign s_axi_rresp_o = st_r.rresp;

  // ==========================================================
  // assertions
  // insertion is checked per smoothed bit, far inside the 250 us budget
  property p_inactive_ones;
    @(posedge clk_i) disable iff (!rst_n_i) !st_r.ctrl[e3dm_pkg::CTRL_ACT_BIT] && rd |=> trib_data_o;
  endproperty
  a_inactive_ones: assert property (p_inactive_ones) else $error("data not all-ones while inactive");
  property p_ssf;
    @(posedge clk_i) disable iff (!rst_n_i) (st_r.lof || st_r.ais || st_r.plm) |=> server_fail_out_o;
  endproperty
  a_ssf: assert property (p_ssf) else $error("server fail missing under defect");
  property p_insert_time;
    @(posedge clk_i) disable iff (!rst_n_i) st_r.ssf && rd |=> trib_data_o;
  endproperty
  a_insert_time: assert property (p_insert_time) else $error("all-ones not inserted in time");
  property p_release_time;
    @(posedge clk_i) disable iff (!rst_n_i) !insert && rd |=> trib_data_o == $past(rbit);
  endproperty
  a_release_time: assert property (p_release_time) else $error("normal data not restored");
  property p_lof_set;
    @(posedge clk_i) disable iff (!rst_n_i) $rose(st_r.lof) |-> $past(st_r.miss) == 3'h3;
  endproperty
  a_lof_set: assert property (p_lof_set) else $error("lof without four misses");
  property p_lof_clr;
    @(posedge clk_i) disable iff (!rst_n_i) $fell(st_r.lof) |-> $past(st_r.fas) == e3dm_pkg::FAS_CHK2;
  endproperty
  a_lof_clr: assert property (p_lof_clr) else $error("lof cleared without three hits");
  property p_plm;
    @(posedge clk_i) disable iff (!rst_n_i) $changed(st_r.lbl_acc) |=>
      st_r.plm == (st_r.lbl_acc != e3dm_pkg::LABEL_EXPECTED);
  endproperty
  a_plm: assert property (p_plm) else $error("label mismatch wrong");
  property p_flof;
    @(posedge clk_i) disable iff (!rst_n_i) frame_loss_fault_o |-> $past(st_r.lof && !st_r.ais && !st_r.plm);
  endproperty
  a_flof: assert property (p_flof) else $error("lof fault under masking defect");
  property p_fais;
    @(posedge clk_i) disable iff (!rst_n_i) all_ones_fault_o |->
      $past(st_r.ais && st_r.ctrl[e3dm_pkg::CTRL_AISREP_BIT] && !st_r.plm && !st_r.s3.tsf);
  endproperty
  a_fais: assert property (p_fais) else $error("ais fault not gated");
  property p_fplm;
    @(posedge clk_i) disable iff (!rst_n_i) label_mismatch_fault_o |-> $past(!st_r.s3.tsf && st_r.plm);
  endproperty
  a_fplm: assert property (p_fplm) else $error("mismatch fault under upstream fail");
  property p_write_edge;
    @(posedge clk_i) disable iff (!rst_n_i) $changed(st_r.wp) |-> $past(edge_w);
  endproperty
  a_write_edge: assert property (p_write_edge) else $error("store written off link edge");
  property p_fs_sync;
    @(posedge clk_i) disable iff (!rst_n_i) frame_start_marker_o |-> $past(st_r.fas) == e3dm_pkg::FAS_SYNC;
  endproperty
  a_fs_sync: assert property (p_fs_sync) else $error("frame start while unaligned");
  // a held address and data pair, or a taken read, is answered on the next edge
  property p_wr_answer;
    @(posedge clk_i) disable iff (!rst_n_i) st_r.aw_v && st_r.w_v && !st_r.bvalid |=> s_axi_bvalid_o;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response missing");
  property p_rd_answer;
    @(posedge clk_i) disable iff (!rst_n_i) s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read response missing");
  c_marker: cover property (@(posedge clk_i) disable iff (!rst_n_i) frame_start_marker_o);
  c_align: cover property (@(posedge clk_i) disable iff (!rst_n_i) $fell(st_r.lof));
  c_ais: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(st_r.ais));
  c_stuff: cover property (@(posedge clk_i) disable iff (!rst_n_i) edge_w && st_r.s3.cls == e3dm_pkg::CLS_S1 && !wr_bit);
endmodule : e3dm_sink

// File: shared/e3dm_pkg.sv
// e3dm_pkg: constants and carrier types for the e3 demapper sink
// assumes a 10 MHz system clock and an AXI4-Lite register port
package e3dm_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LABEL = 8'h08;
  localparam int CTRL_ACT_BIT = 0;
  localparam int CTRL_AISREP_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // payload handling
  localparam logic [7:0] LABEL_EXPECTED = 8'h04;
  localparam logic [2:0] LABEL_ACCEPT_N = 3'h5;
  localparam logic [2:0] LABEL_LAST_IDX = 3'h7;
  localparam logic [2:0] CTRL_MAJORITY = 3'h3;
  localparam int STORE_DEPTH = 64;
  localparam logic [5:0] STORE_HALF = 6'h20;
  localparam logic [5:0] STORE_FULL = 6'h3f;
  localparam logic [15:0] NCO_NOMINAL = 16'h2000;
  localparam logic [15:0] NCO_TRIM = 16'h0100;
  // ==========================================================
  // tributary frame and defect detection
  localparam logic [9:0] FAS_WORD = 10'h3d0;
  localparam logic [10:0] FRAME_LAST = 11'h5ff;
  localparam logic [2:0] LOF_MISSES = 3'h4;
  localparam logic [2:0] AIS_X = 3'h4;
  localparam logic [10:0] AIS_Y_LAST = 11'h5ff;
  localparam logic [2:0] AIS_Z = 3'h5;
  // ==========================================================
  // timing
  localparam int CLK_KHZ = 10000;
  localparam int AIS_TIME_US = 250;
  localparam int AIS_CYC = AIS_TIME_US * CLK_KHZ / 1000;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    CLS_DATA, CLS_FIXED, CLS_C1, CLS_C2, CLS_S1, CLS_S2, CLS_LABEL, CLS_OTHER
  } e3dm_cls_t;
  typedef enum logic [1:0] {FAS_SRCH, FAS_CHK1, FAS_CHK2, FAS_SYNC} e3dm_fas_t;
  typedef struct packed {
    logic lclk;
    logic data;
    e3dm_cls_t cls;
    logic tsf;
  } e3dm_in_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
  } e3dm_word_t;
endpackage : e3dm_pkg
